/* rsc_clock_loss_detector.sv */
// rsc_clock_loss_detector.sv: flags a system clock that stands still.
// assumes i_core_clk is a free-running detector clock independent of the
// system clock, which arrives here as a plain pin level.
`timescale 1ns/10ps
`include "rsc_map.svh"

module rsc_clock_loss_detector #(
	parameter int LIMIT = `RSC_CLK_LOSS_CYC
) (
	// clock and reset
	input  logic i_core_clk,
	input  logic i_rst,
	// observed clock and arming
	input  logic i_sys_clk_pin,
	input  logic i_arm,
	// result
	output logic o_timeout
);

	localparam int CW = $clog2(LIMIT + 1);

	logic          clk_meta;
	logic          clk_sync;
	logic          clk_prev;
	logic [CW-1:0] stall_cnt;

	wire           toggled      = clk_sync ^ clk_prev;
	wire           at_limit     = (stall_cnt == CW'(LIMIT));
	wire [CW-1:0]  next_stall   = (!i_arm || toggled) ? '0 :
	                              at_limit ? stall_cnt : stall_cnt + 1'b1;
	// timeout only after the level has stood longer than the limit
	wire           next_timeout = i_arm && !toggled && at_limit;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			clk_meta  <= 1'b0;
			clk_sync  <= 1'b0;
			clk_prev  <= 1'b0;
			stall_cnt <= '0;
			o_timeout <= 1'b0;
		end else begin
			clk_meta  <= i_sys_clk_pin;
			clk_sync  <= clk_meta;
			clk_prev  <= clk_sync;
			stall_cnt <= next_stall;
			o_timeout <= next_timeout;
		end
	end

endmodule

/* rsc_core_model.sv */
// core model: register port accesses and the external reset pin.
// assumes its tasks are called at the falling clock edge.
`timescale 1ns/10ps

module rsc_core_model
	import rsc_pkg::*;
(
	// clock
	input logic          i_core_clk,
	// register port and reset pin
	output rsc_sfr_req_t o_sfr,
	output logic         o_pin_rst_n
);
	initial begin
		o_sfr = '0;
		o_pin_rst_n = 1'b1;
	end
	// released lines show the inverse so a stale value never passes
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge i_core_clk);
		o_sfr = '{w, !w, a, d};
		@(negedge i_core_clk);
		o_sfr = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic pin(input logic on);
		o_pin_rst_n = !on;
	endtask
endmodule

/* rsc_map.svh */
// rsc_map.svh: addresses, bit positions, reset values and timing counts
// of the reset source controller.
// assumes a 10 MHz core clock; included by bare name by the design files.
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// special-function register address
`define RSC_SFR_ADDR        8'hEF

// bit positions in reset_cause_and_enable
`define RSC_BIT_PIN         0
`define RSC_BIT_PWR         1
`define RSC_BIT_CLK         2
`define RSC_BIT_WDT         3
`define RSC_BIT_SW          4
`define RSC_BIT_CMP         5
`define RSC_BIT_MEM         6
`define RSC_BIT_RTC         7

// reset values
`define RSC_POR_CAUSE       8'h02
`define RSC_SYNC_RST        3'b110
`define RSC_RDATA_RST       8'h00

// timing
`define RSC_CLK_PERIOD_NS   100
`define RSC_CLK_LOSS_US     100
`define RSC_CLK_LOSS_CYC    ((`RSC_CLK_LOSS_US * 1000) / `RSC_CLK_PERIOD_NS)
`define RSC_WDT_DIV         12
`define RSC_HOLD_CYCLES     16

`endif

/* rsc_pkg.sv */
// rsc_pkg.sv: types shared by the reset source controller files.
// assumes rsc_map.svh holds all numeric constants.
package rsc_pkg;

	// reset_cause_and_enable layout, bit 7 first
	typedef struct packed {
		logic rtc;
		logic mem;
		logic cmp;
		logic sw;
		logic wdt;
		logic clk;
		logic pwr;
		logic pin;
	} rsc_cause_t;

	// special-function register access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsc_sfr_req_t;

	// gray along run -> hold -> wait; wait -> run changes both bits
	typedef enum logic [1:0] {
		RSC_ST_RUN  = 2'b00,
		RSC_ST_HOLD = 2'b01,
		RSC_ST_WAIT = 2'b11
	} rsc_state_t;

endpackage

/* rsc_reset_source_controller.sv */
// rsc_reset_source_controller.sv: combines internal and external reset
// sources into one system reset and keeps per-source enables and the
// cause flags of the last reset in one special-function register.
// assumes i_rst is the power-on reset, synchronous to i_core_clk, and that
// the core drives the register port on the same clock.
`timescale 1ns/10ps
`include "rsc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - clock stalled over 100 us forces reset
// - bit 2 reads 1 after clock-loss reset
// - bit 2 write enables clock-loss detector
// - clock-loss reset off in low power, restored
// - internal sources never drive reset pin
// - bit 5 write enables comparator reset
// - comparator low holds device in reset
// - bit 5 reads 1 after comparator reset
// - comparator reset in low power needs wake-up
// - watchdog enabled, clock divided by twelve
// - watchdog overflow resets, bit 3 read-only
// - watchdog reset off in low power, restored
// - illegal memory accesses reset the device
// - bit 6 reads 1 after memory error
// - rtc oscillator fail or alarm resets
// - bit 7 enables rtc reset, flags cause
// - rtc reset still works in low power
// - bit 4 write forces reset, flags cause
// - bit 1 enables supply monitor, flags power-on
// - other bits undefined while bit 1 set
// - bit 0 read-only, flags pin reset
module rsc_reset_source_controller
	import rsc_pkg::*;
#(
	parameter int HOLD_CYCLES = `RSC_HOLD_CYCLES,
	parameter int LOSS_CYCLES = `RSC_CLK_LOSS_CYC
) (
	// clock and power-on reset
	input  logic         i_core_clk,
	input  logic         i_rst,
	// special-function register port
	input  rsc_sfr_req_t i_sfr,
	output logic [7:0]   o_sfr_rdata,
	// pins and analog levels, asynchronous
	input  logic         i_pin_rst_n,
	input  logic         i_sys_clk_pin,
	input  logic         i_cmp0_out,
	input  logic         i_supply_low,
	// power state and wake-up configuration
	input  logic         i_low_power,
	input  logic         i_cmp0_wake_en,
	// watchdog
	input  logic         i_wdt_overflow,
	input  logic         i_wdt_disable,
	// program memory access checks
	input  logic         i_ps_write_en,
	input  logic         i_xdata_write,
	input  logic         i_write_above_lock,
	input  logic         i_table_read_above_lock,
	input  logic         i_branch_above_lock,
	input  logic         i_security_block,
	input  logic         i_supply_mon_on,
	// real-time clock events
	input  logic         i_rtc_osc_fail,
	input  logic         i_rtc_alarm,
	// results
	output logic         o_sys_rst,
	output logic         o_wdt_enable,
	output logic         o_wdt_tick,
	output logic         o_pin_drive_en
);

	localparam int HW = $clog2(HOLD_CYCLES + 1);
	localparam int DW = $clog2(`RSC_WDT_DIV);

	////////////////////////////////////////////////////////////////////////
	// memory access checking

	// a write or erase counts only with the store write enable set
	function automatic logic mem_illegal(
		input logic ps_we,
		input logic xwr,
		input logic wr_above,
		input logic rd_above,
		input logic br_above,
		input logic secured,
		input logic mon_on
	);
		logic store_write;
		store_write = ps_we && xwr;
		mem_illegal = (store_write && wr_above) || rd_above || br_above ||
		              secured || (store_write && !mon_on);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	rsc_state_t    state;
	rsc_cause_t    cause;
	logic [HW-1:0] hold_cnt;
	logic [DW-1:0] wdt_div;
	logic          en_clk;
	logic          en_cmp;
	logic          en_rtc;
	logic          en_pwr;
	logic [2:0]    pin_meta;
	logic [2:0]    pin_sync;
	logic          clk_timeout;

	////////////////////////////////////////////////////////////////////////
	// synchronised pins: {reset pin, comparator, supply low}

	wire pin_rst_n_s = pin_sync[2];
	wire cmp0_s      = pin_sync[1];
	wire supply_lo_s = pin_sync[0];

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pin_meta <= `RSC_SYNC_RST;
			pin_sync <= `RSC_SYNC_RST;
		end else begin
			pin_meta <= {i_pin_rst_n, i_cmp0_out, i_supply_low};
			pin_sync <= pin_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register decode

	wire in_run   = (state == RSC_ST_RUN);
	wire addr_hit = (i_sfr.addr == `RSC_SFR_ADDR);
	// writes while the core sits in reset are dropped
	wire wr_hit   = i_sfr.wr && addr_hit && in_run;
	wire rd_hit   = i_sfr.rd && addr_hit;

	////////////////////////////////////////////////////////////////////////
	// reset sources

	// clock-loss detector disarmed in low power; en_clk itself is kept
	wire clk_arm = en_clk && !i_low_power && in_run;

	rsc_clock_loss_detector #(
		.LIMIT (LOSS_CYCLES)
	) u_clock_loss_detector (
		.i_core_clk    (i_core_clk),
		.i_rst         (i_rst),
		.i_sys_clk_pin (i_sys_clk_pin),
		.i_arm         (clk_arm),
		.o_timeout     (clk_timeout)
	);

	wire src_pin = !pin_rst_n_s;
	// comparator output low means non-inverting below inverting
	wire src_cmp = en_cmp && !cmp0_s && (!i_low_power || i_cmp0_wake_en);
	wire src_pwr = en_pwr && supply_lo_s;
	wire src_clk = clk_timeout;
	// overflow ignored in low power; the watchdog keeps its own setting
	wire src_wdt = i_wdt_overflow && !i_low_power;
	wire src_mem = mem_illegal(i_ps_write_en, i_xdata_write, i_write_above_lock,
	                           i_table_read_above_lock, i_branch_above_lock,
	                           i_security_block, i_supply_mon_on);
	// rtc path has no low-power gating at all
	wire src_rtc = en_rtc && (i_rtc_osc_fail || i_rtc_alarm);
	wire src_sw  = wr_hit && i_sfr.wdata[`RSC_BIT_SW];

	rsc_cause_t cause_now;
	assign cause_now.rtc = src_rtc;
	assign cause_now.mem = src_mem;
	assign cause_now.cmp = src_cmp;
	assign cause_now.sw  = src_sw;
	assign cause_now.wdt = src_wdt;
	assign cause_now.clk = src_clk;
	assign cause_now.pwr = src_pwr;
	assign cause_now.pin = src_pin;

	// one system reset from every enabled source
	wire any_src    = |cause_now;
	// level sources keep the device in reset until they go away
	wire level_hold = src_pin || src_cmp || src_pwr;

	////////////////////////////////////////////////////////////////////////
	// reset sequencer

	wire hold_done = (hold_cnt == '0);

	rsc_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			RSC_ST_RUN: begin
				if (any_src) begin
					next_state = RSC_ST_HOLD;
				end
			end
			RSC_ST_HOLD: begin
				if (hold_done) begin
					next_state = RSC_ST_WAIT;
				end
			end
			RSC_ST_WAIT: begin
				if (!level_hold) begin
					next_state = RSC_ST_RUN;
				end
			end
			default: begin
				next_state = RSC_ST_HOLD;
			end
		endcase
	end

	wire [HW-1:0] next_hold_cnt = (state == RSC_ST_HOLD) ?
	                              (hold_done ? hold_cnt : hold_cnt - 1'b1) :
	                              HW'(HOLD_CYCLES - 1);
	wire          next_sys_rst  = (next_state != RSC_ST_RUN);

	// flags replaced only at the moment a new reset is taken, so each
	// reads 0 unless its own source caused the last reset
	wire capture = in_run && any_src;
	wire rsc_cause_t next_cause = capture ? cause_now : cause;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state    <= RSC_ST_HOLD;
			hold_cnt <= HW'(HOLD_CYCLES - 1);
			o_sys_rst <= 1'b1;
			// power-on clears the other flags, they carry no meaning then
			cause    <= `RSC_POR_CAUSE;
		end else begin
			state    <= next_state;
			hold_cnt <= next_hold_cnt;
			o_sys_rst <= next_sys_rst;
			cause    <= next_cause;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// enables: write-only halves of bits 7, 5, 2, 1

	wire next_en_clk = wr_hit ? i_sfr.wdata[`RSC_BIT_CLK] : en_clk;
	wire next_en_cmp = wr_hit ? i_sfr.wdata[`RSC_BIT_CMP] : en_cmp;
	wire next_en_rtc = wr_hit ? i_sfr.wdata[`RSC_BIT_RTC] : en_rtc;
	wire next_en_pwr = wr_hit ? i_sfr.wdata[`RSC_BIT_PWR] : en_pwr;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			en_clk <= 1'b0;
			en_cmp <= 1'b0;
			en_rtc <= 1'b0;
			en_pwr <= 1'b1;
		end else begin
			en_clk <= next_en_clk;
			en_cmp <= next_en_cmp;
			en_rtc <= next_en_rtc;
			en_pwr <= next_en_pwr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read side: reads always return the cause flags

	// bits 6, 3 and 0 have no write effect at all
	wire [7:0] next_rdata = rd_hit ? cause : 8'h00;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_sfr_rdata <= `RSC_RDATA_RST;
		end else begin
			o_sfr_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog enable and divide-by-twelve tick

	wire          div_wrap       = (wdt_div == DW'(`RSC_WDT_DIV - 1));
	wire [DW-1:0] next_wdt_div   = (next_sys_rst || div_wrap) ? '0 : wdt_div + 1'b1;
	// any reset re-enables it; only the watchdog's own control turns it off
	wire          next_wdt_en    = next_sys_rst ? 1'b1 :
	                               (i_wdt_disable ? 1'b0 : o_wdt_enable);
	wire          next_wdt_tick  = !next_sys_rst && div_wrap;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			wdt_div      <= '0;
			o_wdt_enable <= 1'b1;
			o_wdt_tick   <= 1'b0;
		end else begin
			wdt_div      <= next_wdt_div;
			o_wdt_enable <= next_wdt_en;
			o_wdt_tick   <= next_wdt_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset pin is input only; no internal source ever drives it

	always_ff @(posedge i_core_clk) begin
		o_pin_drive_en <= 1'b0;
	end

endmodule

/* rsc_reset_source_controller_chk.sv */
// checker of the reset source controller: timing relations at its ports.
// assumes it is bound into rsc_reset_source_controller, one clock domain.
`timescale 1ns/10ps

module rsc_reset_source_controller_chk
	import rsc_pkg::*;
#(
	parameter int HOLD_CYCLES = 16
) (
	// clock and reset
	input logic         i_core_clk,
	input logic         i_rst,
	// register port and sources
	input rsc_sfr_req_t i_sfr,
	input logic         i_pin_rst_n,
	input logic         i_cmp0_out,
	input logic         i_low_power,
	input logic         i_wdt_overflow,
	input logic         i_ps_write_en,
	input logic         i_xdata_write,
	input logic         i_write_above_lock,
	input logic         i_table_read_above_lock,
	input logic         i_branch_above_lock,
	input logic         i_security_block,
	input logic         i_supply_mon_on,
	input logic         i_rtc_osc_fail,
	input logic         i_rtc_alarm,
	// results
	input logic         o_sys_rst,
	input logic         o_wdt_enable,
	input logic         o_wdt_tick,
	input logic         o_pin_drive_en
);
	// enables mirrored from accepted writes; cause flags are not modelled
	logic [7:0]  en;
	logic [3:0]  gap;
	logic        seen;
	logic [15:0] rlen;
	wire hit_wr = i_sfr.wr && (i_sfr.addr == 8'hEF) && !o_sys_rst;
	wire mem_bad = (i_ps_write_en && i_xdata_write && (i_write_above_lock || !i_supply_mon_on))
		|| i_table_read_above_lock || i_branch_above_lock || i_security_block;

	always_ff @(posedge i_core_clk) begin
		if (i_rst)
			en <= 8'h02;
		else if (hit_wr)
			en <= i_sfr.wdata & 8'hA6;
	end
	// tick phase restarts after reset, so the first tick is never judged
	always_ff @(posedge i_core_clk) begin
		gap  <= o_wdt_tick ? 4'h0 : gap + {3'h0, gap != 4'hF};
		seen <= !i_rst && !o_sys_rst && (o_wdt_tick || seen);
		rlen <= i_rst ? 16'h00FF : (o_sys_rst ? rlen + 16'h0001 : 16'h0000);
	end

	////////////////////////////////////////
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	chk_pin_undriven: assert property (!o_pin_drive_en)
		else $error("reset pin output enabled");
	chk_tick_period: assert property (seen && !o_sys_rst |->
		(o_wdt_tick ? gap == 4'hB : gap < 4'hB)) else $error("watchdog tick spacing wrong");
	chk_dog_enable: assert property ($rose(o_sys_rst) |=> o_wdt_enable)
		else $error("watchdog not enabled by reset");
	chk_soft_force: assert property (hit_wr && i_sfr.wdata[4] |=> o_sys_rst)
		else $error("software force did not reset");
	chk_dog_overflow: assert property (i_wdt_overflow && !i_low_power && !o_sys_rst
		|=> o_sys_rst) else $error("watchdog overflow did not reset");
	chk_rtc_source: assert property ((i_rtc_alarm || i_rtc_osc_fail) && en[7] && !o_sys_rst
		|=> o_sys_rst) else $error("rtc event did not reset");
	chk_mem_error: assert property (mem_bad && !o_sys_rst |=> o_sys_rst)
		else $error("illegal memory access did not reset");
	chk_cmp_hold: assert property (en[5] && !i_cmp0_out && !i_low_power && !o_sys_rst
		|-> ##[1:4] o_sys_rst) else $error("comparator low did not reset");
	chk_pin_reset: assert property (!i_pin_rst_n && !o_sys_rst |-> ##[1:4] o_sys_rst)
		else $error("reset pin low did not reset");
	chk_hold_length: assert property ($fell(o_sys_rst) |-> rlen > HOLD_CYCLES)
		else $error("system reset too short");

	cov_soft: cover property (hit_wr && i_sfr.wdata[4]);
	cov_lp_rst: cover property (i_low_power && $rose(o_sys_rst));
	cov_tick: cover property (seen && o_wdt_tick);
endmodule

bind rsc_reset_source_controller rsc_reset_source_controller_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_sfr(i_sfr), .i_pin_rst_n(i_pin_rst_n),
	.i_cmp0_out(i_cmp0_out), .i_low_power(i_low_power), .i_wdt_overflow(i_wdt_overflow),
	.i_ps_write_en(i_ps_write_en), .i_xdata_write(i_xdata_write),
	.i_write_above_lock(i_write_above_lock), .i_table_read_above_lock(i_table_read_above_lock),
	.i_branch_above_lock(i_branch_above_lock), .i_security_block(i_security_block),
	.i_supply_mon_on(i_supply_mon_on), .i_rtc_osc_fail(i_rtc_osc_fail),
	.i_rtc_alarm(i_rtc_alarm), .o_sys_rst(o_sys_rst), .o_wdt_enable(o_wdt_enable),
	.o_wdt_tick(o_wdt_tick), .o_pin_drive_en(o_pin_drive_en));

/* rsc_reset_source_controller_test.sv */
// bench of the reset source controller: every source, enables, low power.
// assumes short hold and loss counts; the core model drives the register port.
`timescale 1ns/10ps

module rsc_reset_source_controller_test
	import rsc_pkg::*;
	;
	logic clk, rst, spin, cmp, slow, lp, wake, ovf, doff, pwe, xwr, wab, tab, bab, sec, mon;
	logic ofail, alarm, stop, rd_t, srst, den, tick, pde, pin_n;
	logic [7:0] rdata;
	logic [7:0] exp_q[$];
	logic [7:0] flag[13] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h40, 8'h40,
		8'h40, 8'h40, 8'h80, 8'h80};
	int off_k[5] = '{1, 2, 5, 11, 12};
	int mismatches = 0;
	int total_checks = 0;
	int cyc = 0;
	rsc_sfr_req_t sfr;

	rsc_core_model core (.i_core_clk(clk), .o_sfr(sfr), .o_pin_rst_n(pin_n));
	rsc_reset_source_controller #(.HOLD_CYCLES(2), .LOSS_CYCLES(8)) uut (
		.i_core_clk(clk), .i_rst(rst), .i_sfr(sfr), .o_sfr_rdata(rdata), .i_pin_rst_n(pin_n),
		.i_sys_clk_pin(spin), .i_cmp0_out(cmp), .i_supply_low(slow), .i_low_power(lp),
		.i_cmp0_wake_en(wake), .i_wdt_overflow(ovf), .i_wdt_disable(doff), .i_ps_write_en(pwe),
		.i_xdata_write(xwr), .i_write_above_lock(wab), .i_table_read_above_lock(tab),
		.i_branch_above_lock(bab), .i_security_block(sec), .i_supply_mon_on(mon),
		.i_rtc_osc_fail(ofail), .i_rtc_alarm(alarm), .o_sys_rst(srst), .o_wdt_enable(den),
		.o_wdt_tick(tick), .o_pin_drive_en(pde));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		core.access(1'b0, a, 8'h00);
	endtask
	task automatic drive(input int k, input logic on);
		case (k)
		0: core.pin(on);
		1: slow = on;
		2: stop = on;
		3: ovf = on;
		4: if (on) core.access(1'b1, 8'hEF, 8'hB6);
		5: cmp = !on;
		6: {pwe, xwr, wab} = {3{on}};
		7: tab = on;
		8: bab = on;
		9: sec = on;
		10: {pwe, xwr, mon} = {on, on, !on};
		11: alarm = on;
		default: ofail = on;
		endcase
	endtask
	task automatic settle(input logic lvl);
		int n;
		n = 0;
		while (srst !== lvl && n < 60) begin
			@(negedge clk);
			n++;
		end
		check({7'h00, srst}, {7'h00, lvl});
	endtask
	// enables rewritten first: a pin reset keeps them, only power-on reloads them (bit 1 set, the rest clear)
	task automatic run(input int k, input logic [7:0] en, input logic hit, input logic [7:0] f);
		core.access(1'b1, 8'hEF, en);
		drive(k, 1'b1);
		if (hit) begin
			settle(1'b1);
			drive(k, 1'b0);
			settle(1'b0);
			rd(8'hEF, f);
		end else begin
			repeat (20) @(negedge clk);
			check({7'h00, srst}, 8'h00);
			drive(k, 1'b0);
		end
	endtask

	always @(negedge clk)
		if (!stop)
			spin <= ~spin;
	// read data stands only in the cycle after the read edge
	always @(negedge clk)
		if (rd_t === 1'b1)
			check(rdata, exp_q.pop_front());
	always @(posedge clk) begin
		rd_t <= sfr.rd;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		logic [7:0] a;
		logic [7:0] n_tick;
		{rst, spin, slow, lp, wake, ovf, doff, pwe, xwr, wab, tab, bab, sec} = 13'h1000;
		{mon, ofail, alarm, stop, rd_t} = 5'h10;
		cmp = 1'b1;
		void'($urandom(32'hFFD58095));
		repeat (16) @(negedge clk);
		rst = 1'b0;
		settle(1'b0);
		rd(8'hEF, 8'h02);
		for (int k = 0; k < 13; k++)
			run(k, 8'hA6, 1'b1, flag[k]);
		core.access(1'b1, 8'hEF, 8'h4B);
		rd(8'hEF, 8'h80);
		foreach (off_k[i])
			run(off_k[i], 8'h00, 1'b0, 8'h00);
		lp = 1'b1;
		run(3, 8'hA6, 1'b0, 8'h00);
		run(2, 8'hA6, 1'b0, 8'h00);
		run(5, 8'hA6, 1'b0, 8'h00);
		wake = 1'b1;
		run(5, 8'hA6, 1'b1, 8'h20);
		run(11, 8'hA6, 1'b1, 8'h80);
		lp = 1'b0;
		run(2, 8'hA6, 1'b1, 8'h04);
		doff = 1'b1;
		@(negedge clk);
		doff = 1'b0;
		@(negedge clk);
		check({7'h00, den}, 8'h00);
		run(4, 8'hA6, 1'b1, 8'h10);
		check({7'h00, den}, 8'h01);
		repeat (4) begin
			a = 8'($urandom_range(0, 253));
			if (a >= 8'hEF)
				a = a + 8'h01;
			core.access(1'b1, a, 8'($urandom) | 8'h10);
			rd(a, 8'h00);
		end
		rd(8'hEF, 8'h10);
		repeat (4) @(negedge clk);
		// two ticks in any 24 cycles outside reset
		n_tick = 8'h00;
		repeat (24) begin
			@(negedge clk);
			n_tick = n_tick + {7'h00, tick};
		end
		check(n_tick, 8'h02);
		check({7'h00, pde}, 8'h00);
		give_verdict();
	end
endmodule
